// file: tb/scc_ctrl_assertions.sv
// Port checks for the clock control block.
// Assumes one clock, synchronous active-low reset.
`timescale 1ns/100ps
module scc_ctrl_chk
	import scc_pkg::*;
(
	input wire logic                   clk,
	input wire logic                   rst_b,
	input wire scc_bus_s               bus,
	input wire logic [31:0]            rdata,
	input wire scc_event_s             evt,
	input wire logic                   deep_sleep,
	input wire scc_clkcfg_s            clk_cfg,
	input wire logic                   internal_osc_off,
	input wire logic                   main_osc_off,
	input wire logic [SCC_NPORT-1:0]   gpio_hs_bus,
	input wire logic [SCC_NPERIPH-1:0] periph_run,
	input wire logic                   irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_rd_idle; !$past(bus.rd) |-> rdata == '0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
	property p_flash; bus.rd && bus.addr == SCC_FLASH_OFS |=> rdata == SCC_FLASH_BYTES; endproperty
	a_flash: assert property (p_flash) else $error("flash size wrong");
	property p_mask_off;
		bus.wr && bus.addr == SCC_IMR_OFS && bus.wdata[2:0] == 3'h0 |=> ##1 !irq;
	endproperty
	a_mask_off: assert property (p_mask_off) else $error("masked irq seen");
	// Valid direct sources only; the written divider must reach clk_cfg three cycles after the write
	property p_div;
		bus.wr && bus.addr == SCC_CLKCFG_OFS && !bus.wdata[6] && bus.wdata[10:8] != 3'h3
		&& bus.wdata[10:8] < 3'h5 ##1 !bus.wr
		|=> ##1 clk_cfg.sys_divider_code == $past(bus.wdata[5:0], 3);
	endproperty
	a_div: assert property (p_div) else $error("divider not applied");
	property p_pll; $rose(clk_cfg.select_pll_path) |-> $past(evt.pll_lock, 2); endproperty
	a_pll: assert property (p_pll) else $error("pll used before lock");
	property p_main_on; clk_cfg.src == src_main_osc && $stable(clk_cfg) |-> !main_osc_off; endproperty
	a_main_on: assert property (p_main_on) else $error("active main osc off");
	property p_int_on;
		clk_cfg.src inside {src_internal_osc, src_internal_osc_div4} && $stable(clk_cfg)
		|-> !internal_osc_off;
	endproperty
	a_int_on: assert property (p_int_on) else $error("active int osc off");
	property p_gpio;
		bus.wr && bus.addr == SCC_GPIOBUS_OFS |=> ##1 gpio_hs_bus == $past(bus.wdata[4:0], 2);
	endproperty
	a_gpio: assert property (p_gpio) else $error("gpio bus select wrong");
	property p_run_all; !deep_sleep [*2] |=> &periph_run; endproperty
	a_run_all: assert property (p_run_all) else $error("peripheral stopped awake");
	c_irq: cover property ($rose(irq));
	c_pll: cover property ($rose(clk_cfg.select_pll_path));
	c_gate: cover property (deep_sleep && !(&periph_run));
endmodule

bind scc_ctrl scc_ctrl_chk u_chk (.clk, .rst_b, .bus, .rdata, .evt, .deep_sleep, .clk_cfg,
	.internal_osc_off, .main_osc_off, .gpio_hs_bus, .periph_run, .irq);

// file: tb/scc_ctrl_tb.sv
// Self-checking bench for the clock control block.
// Assumes the checker is bound to the design separately.
`timescale 1ns/100ps
module scc_ctrl_tb
	import scc_pkg::*;
;
	logic        clk, rst_b, hib_present, hib_enabled, deep_sleep;
	logic        internal_osc_off, main_osc_off, pll_enable, irq;
	logic [31:0] rdata, periph_run;
	logic [4:0]  gpio_hs_bus;
	scc_bus_s    bus;
	scc_event_s  evt;
	scc_clkcfg_s clk_cfg;
	int          fails, tests_run, cyc;

	scc_ctrl dut (.clk, .rst_b, .bus, .rdata, .evt, .hib_present, .hib_enabled, .deep_sleep,
		.clk_cfg, .internal_osc_off, .main_osc_off, .pll_enable, .gpio_hs_bus, .periph_run, .irq);

	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	task ck(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("mismatch %0t got %h exp %h", $time, g, e);
		end
	endtask
	task w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk) bus <= '0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk) bus <= '0;
		#1 ck(rdata, e);
	endtask
	task t_reset;
		ck(clk_cfg, 15'h0020);
		ck(periph_run, 32'hFFFFFFFF);
		rd(SCC_CLKCFG_OFS, 32'h100);
		rd(SCC_FLASH_OFS, SCC_FLASH_BYTES);
		rd(8'h24, 32'h0);
		$display("reset test done");
	endtask
	task t_irq;
		for (int i = 0; i < 3; i++) begin
			wr(SCC_IMR_OFS, 32'h0);
			@(posedge clk) evt <= scc_event_s'(3'h4 >> i);
			@(posedge clk) evt <= '0;
			w(2);
			ck(irq, 1'b0);
			rd(SCC_RIS_OFS, 32'h1 << i);
			rd(SCC_MIS_OFS, 32'h0);
			wr(SCC_IMR_OFS, 32'h1 << i);
			w(2);
			ck(irq, 1'b1);
			rd(SCC_MIS_OFS, 32'h1 << i);
			wr(SCC_RIS_OFS, 32'h1 << i);
			w(2);
			ck(irq, 1'b0);
			rd(SCC_RIS_OFS, 32'h0);
		end
		$display("irq test done");
	endtask
	task t_clk;
		wr(SCC_CLKCFG_OFS, 32'h3F);
		w(3);
		ck(clk_cfg, 15'h7E00);
		wr(SCC_OSCCTL_OFS, 32'h3);
		w(2);
		ck({main_osc_off, internal_osc_off}, 2'b01);
		// No hibernation yet, so this write must be dropped
		wr(SCC_CLKCFG_OFS, 32'h300);
		w(3);
		ck(clk_cfg, 15'h7E00);
		@(posedge clk) hib_present <= 1'b1;
		hib_enabled <= 1'b1;
		wr(SCC_CLKCFG_OFS, 32'h300);
		w(3);
		ck(clk_cfg, 15'h0060);
		wr(SCC_OSCCTL_OFS, 32'h0);
		wr(SCC_CLKCFG_OFS, 32'h4040);
		w(4);
		ck(clk_cfg, 15'h0060);
		ck(pll_enable, 1'b1);
		@(posedge clk) evt <= '{1'b0, 1'b1, 1'b0};
		w(3);
		ck(clk_cfg, 15'h0104);
		@(posedge clk) evt <= '0;
		rd(SCC_RIS_OFS, 32'h2);
		wr(SCC_RIS_OFS, 32'h2);
		rd(SCC_RIS_OFS, 32'h0);
		$display("clock test done");
	endtask
	task t_bus;
		wr(SCC_GPIOBUS_OFS, 32'h15);
		w(2);
		ck(gpio_hs_bus, 5'h15);
		wr(SCC_DSLEEP_OFS, 32'h1);
		wr(SCC_STAT_OFS, 32'h1);
		@(posedge clk) deep_sleep <= 1'b1;
		w(2);
		ck(periph_run, 32'h1);
		wr(SCC_STAT_OFS, 32'h0);
		w(3);
		ck(periph_run, 32'hFFFFFFFF);
		@(posedge clk) deep_sleep <= 1'b0;
		$display("bus test done");
	endtask
	task wrap_up;
		$display("fails %0d tests_run %0d", fails, tests_run);
		if (fails == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Generous ceiling; the sequence needs under 150 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			wrap_up;
		end
	end
	initial begin
		rst_b = 0;
		bus = '0;
		evt = '0;
		hib_present = 0;
		hib_enabled = 0;
		deep_sleep = 0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		w(1);
		t_reset;
		t_irq;
		t_clk;
		t_bus;
		wrap_up;
	end
endmodule

// file: verilog/scc_ctrl.sv
// System clock source, divider, oscillator gating and system interrupt control.
// Analog oscillators and PLL are outside; this block drives their controls.
`timescale 1ns/100ps
module scc_ctrl
	import scc_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   rst_b,
	input  wire scc_bus_s               bus,
	output logic [31:0]                 rdata,
	input  wire scc_event_s             evt,
	input  wire logic                   hib_present,
	input  wire logic                   hib_enabled,
	input  wire logic                   deep_sleep,
	output scc_clkcfg_s                 clk_cfg,
	output logic                        internal_osc_off,
	output logic                        main_osc_off,
	output logic                        pll_enable,
	output logic [SCC_NPORT-1:0]        gpio_hs_bus,
	output logic [SCC_NPERIPH-1:0]      periph_run,
	output logic                        irq
);

	scc_clkcfg_s               req_reg;
	scc_clkcfg_s               act_reg;
	logic                      pend_reg;
	logic                      gate_en_reg;
	logic [SCC_NPERIPH-1:0]    ds_en_reg;
	logic [SCC_NPORT-1:0]      hs_reg;
	logic                      int_off_reg;
	logic                      main_off_reg;
	logic [SCC_NIRQ-1:0]       ris_reg;
	logic [SCC_NIRQ-1:0]       imr_reg;
	logic [SCC_NIRQ-1:0]       ev;
	logic [SCC_NIRQ-1:0]       clr;
	logic [SCC_NIRQ-1:0]       mis;
	scc_clkcfg_s               wcfg;
	logic                      w_cfg;
	logic                      src_ok;
	logic                      uses_int;
	logic                      uses_main;

	assign ev = {evt.brownout, evt.pll_lock, evt.main_osc_pup};
	assign mis = ris_reg & imr_reg;
	assign w_cfg = bus.wr && bus.addr == SCC_CLKCFG_OFS;
	assign clr = (bus.wr && bus.addr == SCC_RIS_OFS) ? bus.wdata[SCC_NIRQ-1:0] : '0;

	always_comb begin
		wcfg.sys_divider_code = bus.wdata[SCC_DIV_LSB +: 6];
		wcfg.select_pll_path = bus.wdata[SCC_PLL_BIT];
		wcfg.src = scc_src_e'(bus.wdata[SCC_SRC_LSB +: 3]);
		wcfg.crystal_freq_code = bus.wdata[SCC_XTAL_LSB +: 5];
		// Illegal codes and unavailable 32k source leave the request unchanged
		unique case (wcfg.src)
			src_main_osc, src_internal_osc, src_internal_osc_div4, src_internal_30k: begin
				src_ok = 1'b1;
			end
			src_external_32k: begin
				src_ok = hib_present && hib_enabled;
			end
			default: begin
				src_ok = 1'b0;
			end
		endcase
	end

	// Oscillators feeding the active clock cannot be switched off
	assign uses_int = act_reg.src == src_internal_osc || act_reg.src == src_internal_osc_div4;
	assign uses_main = act_reg.src == src_main_osc;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			req_reg <= '{SCC_DIV_RST, 1'b0, src_internal_osc, SCC_XTAL_RST};
			pend_reg <= 1'b0;
		end else if (w_cfg && src_ok) begin
			req_reg <= wcfg;
			pend_reg <= 1'b1;
		end else if (pend_reg && (!req_reg.select_pll_path || evt.pll_lock)) begin
			pend_reg <= 1'b0;
		end
	end

	// Active config moves only once pending switch is safe
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			act_reg <= '{SCC_DIV_RST, 1'b0, src_internal_osc, SCC_XTAL_RST};
		end else if (pend_reg && (!req_reg.select_pll_path || evt.pll_lock)) begin
			act_reg <= req_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			int_off_reg <= 1'b0;
			main_off_reg <= 1'b0;
		end else if (bus.wr && bus.addr == SCC_OSCCTL_OFS) begin
			int_off_reg <= bus.wdata[0];
			main_off_reg <= bus.wdata[1];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			internal_osc_off <= 1'b0;
			main_osc_off <= 1'b0;
			pll_enable <= 1'b0;
			clk_cfg <= '{SCC_DIV_RST, 1'b0, src_internal_osc, SCC_XTAL_RST};
		end else begin
			internal_osc_off <= int_off_reg && !uses_int;
			main_osc_off <= main_off_reg && !uses_main && !act_reg.select_pll_path;
			pll_enable <= req_reg.select_pll_path || act_reg.select_pll_path;
			clk_cfg <= act_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			hs_reg <= '0;
			gate_en_reg <= 1'b0;
			ds_en_reg <= '0;
		end else begin
			if (bus.wr && bus.addr == SCC_GPIOBUS_OFS) begin
				hs_reg <= bus.wdata[SCC_NPORT-1:0];
			end
			if (bus.wr && bus.addr == SCC_DSLEEP_OFS) begin
				ds_en_reg <= bus.wdata;
			end
			if (bus.wr && bus.addr == SCC_STAT_OFS) begin
				gate_en_reg <= bus.wdata[0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			gpio_hs_bus <= '0;
			periph_run <= '1;
		end else begin
			gpio_hs_bus <= hs_reg;
			periph_run <= (deep_sleep && gate_en_reg) ? ds_en_reg : '1;
		end
	end

	// Set wins over clear so a simultaneous event is never lost
	genvar i;
	generate
		for (i = 0; i < SCC_NIRQ; i++) begin : g_irq
			always_ff @(posedge clk) begin
				if (!rst_b) begin
					ris_reg[i] <= 1'b0;
				end else if (ev[i]) begin
					ris_reg[i] <= 1'b1;
				end else if (clr[i]) begin
					ris_reg[i] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			imr_reg <= '0;
			irq <= 1'b0;
		end else begin
			if (bus.wr && bus.addr == SCC_IMR_OFS) begin
				imr_reg <= bus.wdata[SCC_NIRQ-1:0];
			end
			irq <= |mis;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rdata <= '0;
		end else if (bus.rd) begin
			unique case (bus.addr)
				SCC_CLKCFG_OFS: rdata <= {15'h0, req_reg.crystal_freq_code, 1'b0,
					req_reg.src, 1'b0, req_reg.select_pll_path, req_reg.sys_divider_code};
				SCC_OSCCTL_OFS: rdata <= {30'h0, main_off_reg, int_off_reg};
				SCC_GPIOBUS_OFS: rdata <= {27'h0, hs_reg};
				SCC_DSLEEP_OFS: rdata <= ds_en_reg;
				SCC_RIS_OFS: rdata <= {29'h0, ris_reg};
				SCC_IMR_OFS: rdata <= {29'h0, imr_reg};
				SCC_MIS_OFS: rdata <= {29'h0, mis};
				SCC_FLASH_OFS: rdata <= SCC_FLASH_BYTES;
				SCC_STAT_OFS: rdata <= {30'h0, pend_reg, gate_en_reg};
				default: rdata <= '0;
			endcase
		end else begin
			rdata <= '0;
		end
	end

endmodule

// file: verilog/scc_pkg.sv
// Constants, register map and carrier types for the system clock control block.
// Assumes a single clock domain with synchronous active-low reset.
// What this block does
// - Divide selected source by 1 to 64
// - Choose PLL path or direct oscillator path
// - Exactly one of five oscillator sources
// - External 32k only with hibernation enabled
// - Separate internal and main oscillator disables
// - Never disable the oscillator clocking device
// - Deep-sleep gating keeps only enabled peripherals
// - Per-port high-speed or peripheral bus select
// - Three interrupt sources, write one to clear
// - Only enabled sources reach interrupt line
// - Flash size in bytes readable
// - Raw and masked status both readable
package scc_pkg;

	localparam logic [7:0] SCC_CLKCFG_OFS = 8'h00;
	localparam logic [7:0] SCC_OSCCTL_OFS = 8'h04;
	localparam logic [7:0] SCC_GPIOBUS_OFS = 8'h08;
	localparam logic [7:0] SCC_DSLEEP_OFS = 8'h0C;
	localparam logic [7:0] SCC_RIS_OFS = 8'h10;
	localparam logic [7:0] SCC_IMR_OFS = 8'h14;
	localparam logic [7:0] SCC_MIS_OFS = 8'h18;
	localparam logic [7:0] SCC_FLASH_OFS = 8'h1C;
	localparam logic [7:0] SCC_STAT_OFS = 8'h20;

	// Clock config field positions
	localparam int SCC_DIV_LSB = 0;
	localparam int SCC_PLL_BIT = 6;
	localparam int SCC_SRC_LSB = 8;
	localparam int SCC_XTAL_LSB = 12;

	localparam int SCC_NPORT = 5;
	localparam int SCC_NPERIPH = 32;
	localparam int SCC_NIRQ = 3;
	localparam int SCC_IRQ_MOSC = 0;
	localparam int SCC_IRQ_PLL = 1;
	localparam int SCC_IRQ_BOR = 2;

	localparam logic [5:0] SCC_DIV_RST = 6'h00;
	localparam logic [4:0] SCC_XTAL_RST = 5'h00;
	localparam logic [4:0] SCC_XTAL_MIN_PLL = 5'h04;
	localparam logic [31:0] SCC_FLASH_BYTES = 32'h0001_0000;

	typedef enum logic [2:0] {
		src_main_osc,
		src_internal_osc,
		src_internal_osc_div4,
		src_external_32k,
		src_internal_30k
	} scc_src_e;

	typedef struct packed {
		logic [5:0] sys_divider_code;
		logic       select_pll_path;
		scc_src_e   src;
		logic [4:0] crystal_freq_code;
	} scc_clkcfg_s;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} scc_bus_s;

	typedef struct packed {
		logic main_osc_pup;
		logic pll_lock;
		logic brownout;
	} scc_event_s;

endpackage
